//--- logic/csr_charger_regs.v
// Purpose: Serial slave and first register bank of a one-cell charger
// Assumes: Bus lines and pins arrive asynchronously, one system clock
// Notes:   Data line is open drain, driven only low
`timescale 1ns/10ps
`include "csr_map.vh"

module csr_charger_regs #(
  parameter [6:0] SLAVE_ADDR   = `CSR_SLAVE_ADDR,
  parameter       HAS_HOST_PIN = 1,
  parameter [7:0] IDENT_VALUE  = 8'h5A, // Arbitrary value
  parameter [1:0] LIMIT_RESET  = 2'h0
) (
  input  wire       clock,
  input  wire       resetn,
  input  wire       scl_i,
  input  wire       sda_i,
  output wire       sda_o,
  output reg        sda_oe,
  input  wire       host_role_pin,
  input  wire       safety_limit_reset_pin,
  input  wire [1:0] charge_phase,
  input  wire       boost_active,
  input  wire [2:0] fault_code,
  output reg        timer_clear_or_host_pin,
  output reg        stat_pin_enable,
  output wire [1:0] input_limit,
  output wire       weak_battery_level_hi,
  output wire       weak_battery_level_lo,
  output wire       finish_on_low_current,
  output wire       charger_disable,
  output wire       input_float_mode,
  output wire       step_up_select,
  output reg  [7:0] voltage_setting,
  output reg  [7:0] current_setting,
  output reg        hs_active
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [8:0] ST_IDLE      = 9'h001;
  localparam [8:0] ST_ADDR      = 9'h002;
  localparam [8:0] ST_ADDR_ACK  = 9'h004;
  localparam [8:0] ST_PTR       = 9'h008;
  localparam [8:0] ST_PTR_ACK   = 9'h010;
  localparam [8:0] ST_WDATA     = 9'h020;
  localparam [8:0] ST_WDATA_ACK = 9'h040;
  localparam [8:0] ST_RDATA     = 9'h080;
  localparam [8:0] ST_RDATA_ACK = 9'h100;

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam [7:0] CONTROL_RESET = `CSR_CONTROL_RESET;
  localparam [7:0] CONTROL_INIT  = {LIMIT_RESET, CONTROL_RESET[5:0]};

  // ****************************************************************
  // Declarations
  // ****************************************************************
  wire [3:0] pin_level;
  wire       scl;
  wire       sda;
  wire       role_level;
  wire [7:0] read_data;
  wire       scl_rise;
  wire       scl_fall;
  wire       start_seen;
  wire       stop_seen;
  wire       commit;
  wire       byte_done;
  reg        scl_prev;
  reg        sda_prev;
  reg  [8:0] state;
  reg  [3:0] bit_cnt;
  reg  [7:0] shift_in;
  reg  [7:0] shift_out;
  reg  [7:0] pointer;
  reg        read_dir;
  reg  [7:0] control;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function is_master_code;
    input [7:0] value;
    begin
      is_master_code = (value[7:3] == `CSR_HS_CODE_TOP);
    end
  endfunction

  function [3:0] count_up;
    input [3:0] value;
    begin
      count_up = value + 4'h1;
    end
  endfunction

  function [7:0] shift_bit;
    input [7:0] value;
    input       bit_in;
    begin
      shift_bit = {value[6:0], bit_in};
    end
  endfunction

  function [7:0] load_shift;
    input [7:0] value;
    begin
      load_shift = {value[6:0], 1'b0};
    end
  endfunction

  function is_own_address;
    input [7:0] value;
    begin
      is_own_address = (value[7:1] == SLAVE_ADDR);
    end
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  csr_pin_sync #(
    .WIDTH    (4),
    .INIT_VAL (4'hF)
  ) u_sync (
    .clock  (clock),
    .resetn (resetn),
    .pin_in ({safety_limit_reset_pin, host_role_pin, sda_i, scl_i}),
    .level  (pin_level)
  );

  assign scl        = pin_level[0];
  assign sda        = pin_level[1];
  assign role_level = (HAS_HOST_PIN != 0) ? pin_level[2] : pin_level[3];

  // ****************************************************************
  // Bus events
  // ****************************************************************
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end else begin
      scl_prev <= scl;
      sda_prev <= sda;
    end
  end

  assign scl_rise   = scl & ~scl_prev;
  assign scl_fall   = ~scl & scl_prev;
  assign start_seen = scl & scl_prev & sda_prev & ~sda;
  assign stop_seen  = scl & scl_prev & ~sda_prev & sda;
  assign byte_done  = scl_fall & (bit_cnt == `CSR_BITS_PER_BYTE);
  assign commit     = (state == ST_WDATA_ACK) & scl_fall & ~start_seen & ~stop_seen;
  assign sda_o      = 1'b0;

  // ****************************************************************
  // Serial engine
  // ****************************************************************
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state     <= ST_IDLE;
      bit_cnt   <= 4'h0;
      shift_in  <= 8'h00;
      shift_out <= 8'h00;
      pointer   <= 8'h00;
      read_dir  <= 1'b0;
      sda_oe    <= 1'b0;
      hs_active <= 1'b0;
    end else if (start_seen) begin
      state   <= ST_ADDR;
      bit_cnt <= 4'h0;
      sda_oe  <= 1'b0;
    end else if (stop_seen) begin
      state     <= ST_IDLE;
      sda_oe    <= 1'b0;
      hs_active <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          sda_oe <= 1'b0;
        end
        ST_ADDR: begin
          if (scl_rise) begin
            shift_in <= shift_bit(shift_in, sda);
            bit_cnt  <= count_up(bit_cnt);
          end else if (byte_done) begin
            if (is_master_code(shift_in)) begin
              hs_active <= 1'b1;
              state     <= ST_IDLE;
            end else if (is_own_address(shift_in)) begin
              read_dir <= shift_in[0];
              sda_oe   <= 1'b1;
              state    <= ST_ADDR_ACK;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            bit_cnt <= 4'h0;
            if (read_dir) begin
              sda_oe    <= ~read_data[7];
              shift_out <= load_shift(read_data);
              state     <= ST_RDATA;
            end else begin
              sda_oe <= 1'b0;
              state  <= ST_PTR;
            end
          end
        end
        ST_PTR: begin
          if (scl_rise) begin
            shift_in <= shift_bit(shift_in, sda);
            bit_cnt  <= count_up(bit_cnt);
          end else if (byte_done) begin
            pointer <= shift_in;
            sda_oe  <= 1'b1;
            state   <= ST_PTR_ACK;
          end
        end
        ST_PTR_ACK: begin
          if (scl_fall) begin
            sda_oe  <= 1'b0;
            bit_cnt <= 4'h0;
            state   <= ST_WDATA;
          end
        end
        ST_WDATA: begin
          if (scl_rise) begin
            shift_in <= shift_bit(shift_in, sda);
            bit_cnt  <= count_up(bit_cnt);
          end else if (byte_done) begin
            sda_oe <= 1'b1;
            state  <= ST_WDATA_ACK;
          end
        end
        ST_WDATA_ACK: begin
          if (scl_fall) begin
            sda_oe  <= 1'b0;
            bit_cnt <= 4'h0;
            state   <= ST_PTR;
          end
        end
        ST_RDATA: begin
          if (scl_rise) begin
            bit_cnt <= count_up(bit_cnt);
          end else if (byte_done) begin
            sda_oe <= 1'b0;
            state  <= ST_RDATA_ACK;
          end else if (scl_fall) begin
            sda_oe    <= ~shift_out[7];
            shift_out <= load_shift(shift_out);
          end
        end
        ST_RDATA_ACK: begin
          if (scl_rise) begin
            shift_in <= shift_bit(shift_in, sda);
          end else if (scl_fall) begin
            bit_cnt <= 4'h0;
            if (!shift_in[0]) begin
              sda_oe    <= ~read_data[7];
              shift_out <= load_shift(read_data);
              state     <= ST_RDATA;
            end else begin
              state <= ST_IDLE;
            end
          end
        end
        default: begin
          state  <= ST_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // ****************************************************************
  // Register bank
  // ****************************************************************
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      timer_clear_or_host_pin <= 1'b0;
      stat_pin_enable         <= `CSR_STAT_EN_RESET;
      control                 <= CONTROL_INIT;
      voltage_setting         <= `CSR_VOLTAGE_RESET;
      current_setting         <= `CSR_CURRENT_RESET;
    end else begin
      timer_clear_or_host_pin <= 1'b0;
      current_setting[`CSR_BIT_CUR_RESET] <= 1'b0;
      if (commit) begin
        case (pointer)
          `CSR_REG_STATUS: begin
            timer_clear_or_host_pin <= shift_in[`CSR_BIT_TIMER_CLEAR];
            stat_pin_enable         <= shift_in[`CSR_BIT_STAT_EN];
          end
          `CSR_REG_CONTROL: begin
            control <= shift_in;
          end
          `CSR_REG_VOLTAGE: begin
            voltage_setting <= shift_in;
          end
          `CSR_REG_CURRENT: begin
            current_setting <= shift_in;
          end
          default: begin
            control <= control;
          end
        endcase
      end
    end
  end

  // ****************************************************************
  // Control fields
  // ****************************************************************
  assign input_limit           = control[`CSR_BIT_LIMIT_HI:`CSR_BIT_LIMIT_LO];
  assign weak_battery_level_hi = control[`CSR_BIT_WEAK_HI];
  assign weak_battery_level_lo = control[`CSR_BIT_WEAK_LO];
  assign finish_on_low_current = control[`CSR_BIT_FINISH];
  assign charger_disable       = control[`CSR_BIT_DISABLE];
  assign input_float_mode      = control[`CSR_BIT_FLOAT];
  assign step_up_select        = control[`CSR_BIT_STEP_UP];

  // ****************************************************************
  // Read path
  // ****************************************************************
  csr_read_mux u_read (
    .pointer      (pointer),
    .role_level   (role_level),
    .stat_en      (stat_pin_enable),
    .charge_phase (charge_phase),
    .boost_active (boost_active),
    .fault_code   (fault_code),
    .control      (control),
    .voltage      (voltage_setting),
    .ident        (IDENT_VALUE),
    .current      (current_setting),
    .read_data    (read_data)
  );

endmodule // csr_charger_regs

//--- logic/csr_charger_regs_pad_check.v
// Purpose: Spare design file, holds no module
// Assumes: Nothing from the register bank
// Notes:   File lists may name it without effect

//--- logic/csr_map.vh
// Purpose: Constants for the charger status and control register bank
// Assumes: Serial slave sampled on one system clock
// Notes:   Offsets are register pointer values carried in the serial stream
`ifndef CSR_MAP_VH
`define CSR_MAP_VH

// ****************************************************************
// Register pointers
// ****************************************************************
`define CSR_REG_STATUS      8'h00
`define CSR_REG_CONTROL     8'h01
`define CSR_REG_VOLTAGE     8'h02
`define CSR_REG_IDENT       8'h03
`define CSR_REG_CURRENT     8'h04

// ****************************************************************
// Reset values and unmapped read data
// ****************************************************************
`define CSR_CONTROL_RESET   8'h30
`define CSR_VOLTAGE_RESET   8'h0A
`define CSR_CURRENT_RESET   8'h01
`define CSR_STAT_EN_RESET   1'b1
`define CSR_UNMAPPED_DATA   8'hFF

// ****************************************************************
// Field positions
// ****************************************************************
`define CSR_BIT_TIMER_CLEAR 7
`define CSR_BIT_STAT_EN     6
`define CSR_BIT_LIMIT_HI    7
`define CSR_BIT_LIMIT_LO    6
`define CSR_BIT_WEAK_HI     5
`define CSR_BIT_WEAK_LO     4
`define CSR_BIT_FINISH      3
`define CSR_BIT_DISABLE     2
`define CSR_BIT_FLOAT       1
`define CSR_BIT_STEP_UP     0
`define CSR_BIT_CUR_RESET   7

// ****************************************************************
// Serial protocol
// ****************************************************************
`define CSR_SLAVE_ADDR      7'h6B
`define CSR_HS_CODE_TOP     5'h01
`define CSR_BITS_PER_BYTE   4'h8

`endif

//--- logic/csr_pin_sync.v
// Purpose: Three-stage synchroniser with agreement filter
// Assumes: Inputs asynchronous to clock
// Notes:   Level moves only when stages two and three agree
`timescale 1ns/10ps

module csr_pin_sync #(
  parameter                 WIDTH    = 4,
  parameter [WIDTH-1:0]     INIT_VAL = {WIDTH{1'b1}}
) (
  input  wire               clock,
  input  wire               resetn,
  input  wire [WIDTH-1:0]   pin_in,
  output reg  [WIDTH-1:0]   level
);

  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;
  reg [WIDTH-1:0] stage3;
  integer         i;

  // ****************************************************************
  // Sampling chain
  // ****************************************************************
  always @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      stage1 <= INIT_VAL;
      stage2 <= INIT_VAL;
      stage3 <= INIT_VAL;
      level  <= INIT_VAL;
    end else begin
      stage1 <= pin_in;
      stage2 <= stage1;
      stage3 <= stage2;
      for (i = 0; i < WIDTH; i = i + 1) begin
        if (stage2[i] == stage3[i]) begin
          level[i] <= stage3[i];
        end
      end
    end
  end

endmodule // csr_pin_sync

//--- logic/csr_read_mux.v
// Purpose: Read data selection for the register bank
// Assumes: Pointer from serial engine, fields from register flops and status input pins
// Notes:   Purely combinational
`timescale 1ns/10ps
`include "csr_map.vh"

module csr_read_mux (
  input  wire [7:0] pointer,
  input  wire       role_level,
  input  wire       stat_en,
  input  wire [1:0] charge_phase,
  input  wire       boost_active,
  input  wire [2:0] fault_code,
  input  wire [7:0] control,
  input  wire [7:0] voltage,
  input  wire [7:0] ident,
  input  wire [7:0] current,
  output reg  [7:0] read_data
);

  // ****************************************************************
  // Selection
  // ****************************************************************
  always @* begin
    case (pointer)
      `CSR_REG_STATUS: begin
        read_data = {role_level, stat_en, charge_phase, boost_active, fault_code};
      end
      `CSR_REG_CONTROL: begin
        read_data = control;
      end
      `CSR_REG_VOLTAGE: begin
        read_data = voltage;
      end
      `CSR_REG_IDENT: begin
        read_data = ident;
      end
      `CSR_REG_CURRENT: begin
        read_data = current & 8'h7F;
      end
      default: begin
        read_data = `CSR_UNMAPPED_DATA;
      end
    endcase
  end

endmodule // csr_read_mux

//--- tb/csr_charger_regs_checker.sv
// Purpose: Port checks for the charger register bank
// Assumes: Bound to csr_charger_regs, pins seen raw
// Notes:   Bus timing judged against the raw clock pin
`timescale 1ns/10ps

module csr_charger_regs_checker #(
  parameter [1:0] LIMIT_RESET = 2'h0
) (
  input wire       clock,
  input wire       resetn,
  input wire       scl_i,
  input wire       sda_i,
  input wire       sda_o,
  input wire       sda_oe,
  input wire       timer_clear_or_host_pin,
  input wire       stat_pin_enable,
  input wire [1:0] input_limit,
  input wire       weak_battery_level_hi,
  input wire       weak_battery_level_lo,
  input wire       finish_on_low_current,
  input wire       charger_disable,
  input wire       input_float_mode,
  input wire       step_up_select,
  input wire       hs_active
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire [7:0] ctl = {input_limit, weak_battery_level_hi, weak_battery_level_lo,
                    finish_on_low_current, charger_disable, input_float_mode, step_up_select};

  a_reset_values: assert property ($rose(resetn) |->
    ctl == {LIMIT_RESET, 6'h30} && stat_pin_enable && !hs_active && !sda_oe)
    else $error("control bank not at reset values");
  a_open_drain: assert property (sda_o == 1'b0)
    else $error("data line driven high");
  a_pulse_single: assert property (timer_clear_or_host_pin |=> !timer_clear_or_host_pin)
    else $error("timer clear longer than one cycle");
  a_pulse_scl_low: assert property (timer_clear_or_host_pin |-> !scl_i)
    else $error("timer clear outside clock low");
  a_ctl_commit_low: assert property ($past(resetn) && !$stable(ctl) |-> !scl_i)
    else $error("control changed while clock high");
  a_commit_on_ack: assert property ($past(resetn) && !$stable(ctl) |-> $past(sda_oe))
    else $error("control changed outside an acknowledge");
  a_en_commit_low: assert property ($past(resetn) && !$stable(stat_pin_enable) |-> !scl_i)
    else $error("status enable changed while clock high");
  a_ack_edge_low: assert property ($changed(sda_oe) |-> !scl_i)
    else $error("data drive changed while clock high");
  a_hs_no_ack: assert property ($rose(hs_active) |-> !sda_oe [*8])
    else $error("master code acknowledged");
  a_hs_stop_clear: assert property (scl_i && $rose(sda_i) && hs_active |-> ##[1:12] !hs_active)
    else $error("fast mode kept after stop");

  c_pulse: cover property (timer_clear_or_host_pin);
  c_hs: cover property ($rose(hs_active));
  c_ack: cover property ($rose(sda_oe));
endmodule // csr_charger_regs_checker

bind csr_charger_regs csr_charger_regs_checker #(.LIMIT_RESET(LIMIT_RESET)) u_chk (
  .clock(clock), .resetn(resetn), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe), .timer_clear_or_host_pin(timer_clear_or_host_pin),
  .stat_pin_enable(stat_pin_enable), .input_limit(input_limit),
  .weak_battery_level_hi(weak_battery_level_hi), .weak_battery_level_lo(weak_battery_level_lo),
  .finish_on_low_current(finish_on_low_current), .charger_disable(charger_disable),
  .input_float_mode(input_float_mode), .step_up_select(step_up_select),
  .hs_active(hs_active));

//--- tb/csr_i2c_master.sv
// Purpose: Serial bus master model
// Assumes: Data line pulled up, released means high
// Notes:   Clock pin idles high between frames
`timescale 1ns/10ps

module csr_i2c_master #(
  parameter Q = 8
) (
  input  wire clock,
  input  wire sda_in,
  output reg  scl,
  output reg  sda_low
);
  initial begin
    scl = 1'h1;
    sda_low = 1'h0;
  end

  task automatic waitq;
    repeat (Q) @(negedge clock);
  endtask

  // Start, also usable as repeated start
  task automatic bus_start;
    sda_low = 1'h0;
    waitq;
    scl = 1'h1;
    waitq;
    sda_low = 1'h1;
    waitq;
    scl = 1'h0;
    waitq;
  endtask

  task automatic bus_stop;
    sda_low = 1'h1;
    waitq;
    scl = 1'h1;
    waitq;
    sda_low = 1'h0;
    waitq;
  endtask

  // Eight bits out MSB first plus ninth bit; returns what the line showed
  task automatic byte_io(input [7:0] tx, input ack_bit, output [7:0] rx, output ack_seen);
    logic [8:0] o;
    logic [8:0] s;
    o = {tx, ack_bit};
    for (int i = 8; i >= 0; i--) begin
      sda_low = ~o[i];
      waitq;
      scl = 1'h1;
      waitq;
      s[i] = sda_in;
      waitq;
      scl = 1'h0;
      waitq;
    end
    rx = s[8:1];
    ack_seen = s[0];
  endtask
endmodule // csr_i2c_master

//--- tb/tb_charger_status_control_regs.sv
// Purpose: Self-checking bench for the charger register bank
// Assumes: Master model on the bus, status inputs from the bench
// Notes:   Rows first, then awkward cases and reset
`timescale 1ns/10ps
`include "csr_map.vh"

module tb_charger_status_control_regs;
  localparam [6:0] ADDR = `CSR_SLAVE_ADDR;
  logic       clock = 1'h0;
  logic       resetn = 1'h0;
  logic       host_role_pin = 1'h1;
  logic       safety_pin = 1'h0;
  logic       boost_active = 1'h0;
  logic [1:0] charge_phase = 2'h0;
  logic [2:0] fault_code = 3'h0;
  wire        scl, sda_low, sda_oe, pulse, stat_en, hs, wh, wl, fin, dis, flt, stp;
  wire  [1:0] lim;
  wire  [7:0] vs, cs;
  wire        sda_line = ~(sda_low | sda_oe);
  wire  [7:0] ctl = {lim, wh, wl, fin, dis, flt, stp};
  int         n_mismatch, checks, cyc, pulses;
  logic [7:0] rx;
  logic       ack;
  logic [30:0] rows [19] = '{
    {8'h01, 1'h1, 8'hC5, 6'h00, 8'hC5}, {8'h01, 1'h1, 8'h7A, 6'h00, 8'h7A},
    {8'h01, 1'h1, 8'h8B, 6'h00, 8'h8B}, {8'h01, 1'h1, 8'h3A, 6'h00, 8'h3A},
    {8'h00, 1'h0, 8'h00, 6'h00, 8'hC0}, {8'h00, 1'h0, 8'h00, 6'h11, 8'hD1},
    {8'h00, 1'h0, 8'h00, 6'h2A, 8'hEA}, {8'h00, 1'h0, 8'h00, 6'h33, 8'hF3},
    {8'h00, 1'h0, 8'h00, 6'h1C, 8'hDC}, {8'h00, 1'h0, 8'h00, 6'h05, 8'hC5},
    {8'h00, 1'h0, 8'h00, 6'h26, 8'hE6}, {8'h00, 1'h0, 8'h00, 6'h3F, 8'hFF},
    {8'h00, 1'h1, 8'h3F, 6'h05, 8'h85}, {8'h00, 1'h1, 8'h40, 6'h05, 8'hC5},
    {8'h03, 1'h1, 8'h00, 6'h05, 8'h5A}, {8'h05, 1'h1, 8'h12, 6'h05, 8'hFF},
    {8'h02, 1'h1, 8'hA5, 6'h05, 8'hA5}, {8'h04, 1'h1, 8'hC3, 6'h05, 8'h43},
    {8'h80, 1'h0, 8'h00, 6'h05, 8'hFF}};

  csr_i2c_master m (.clock(clock), .sda_in(sda_line), .scl(scl), .sda_low(sda_low));

  csr_charger_regs dut (
    .clock(clock), .resetn(resetn), .scl_i(scl), .sda_i(sda_line), .sda_o(), .sda_oe(sda_oe),
    .host_role_pin(host_role_pin), .safety_limit_reset_pin(safety_pin),
    .charge_phase(charge_phase), .boost_active(boost_active), .fault_code(fault_code),
    .timer_clear_or_host_pin(pulse), .stat_pin_enable(stat_en), .input_limit(lim),
    .weak_battery_level_hi(wh), .weak_battery_level_lo(wl), .finish_on_low_current(fin),
    .charger_disable(dis), .input_float_mode(flt), .step_up_select(stp),
    .voltage_setting(vs), .current_setting(cs), .hs_active(hs));

  always #4 clock = ~clock;
  always @(posedge pulse) pulses++;
  always @(posedge clock) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      final_report;
    end
  end

  task automatic final_report;
    if (n_mismatch == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input [7:0] got, input [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic send(input [7:0] b, input exp_ack);
    m.byte_io(b, 1'h1, rx, ack);
    chk({7'h00, ack}, {7'h00, exp_ack});
  endtask

  task automatic wr_reg(input [7:0] p, input [7:0] d);
    m.bus_start;
    send({ADDR, 1'h0}, 1'h0);
    send(p, 1'h0);
    send(d, 1'h0);
    m.bus_stop;
  endtask

  task automatic rd_reg(input [7:0] p, input [7:0] exp);
    m.bus_start;
    send({ADDR, 1'h0}, 1'h0);
    send(p, 1'h0);
    m.bus_start;
    send({ADDR, 1'h1}, 1'h0);
    m.byte_io(8'hFF, 1'h1, rx, ack);
    m.bus_stop;
    chk(rx, exp);
  endtask

  initial begin
    logic [7:0] p, d, e;
    logic       w;
    logic [5:0] st;
    repeat (16) @(negedge clock);
    resetn = 1'h1;
    repeat (8) @(negedge clock);
    foreach (rows[i]) begin
      {p, w, d, st, e} = rows[i];
      {charge_phase, boost_active, fault_code} = st;
      if (w) wr_reg(p, d);
      rd_reg(p, e);
      if (p == 8'h01) chk(ctl, e);
      if (p == 8'h02) chk(vs, e);
      if (p == 8'h04) chk(cs, e);
    end
    host_role_pin = 1'h0;
    safety_pin = 1'h1;
    pulses = 0;
    wr_reg(8'h00, 8'h80);
    chk(pulses[7:0], 8'h01);
    chk({7'h00, stat_en}, 8'h00);
    rd_reg(8'h00, 8'h05);
    m.bus_start;
    send({ADDR, 1'h0}, 1'h0);
    send(8'h01, 1'h0);
    send(8'h55, 1'h0);
    send(8'h00, 1'h0);
    send(8'hC0, 1'h0);
    m.bus_stop;
    chk(ctl, 8'h55);
    chk({7'h00, stat_en}, 8'h01);
    chk(pulses[7:0], 8'h02);
    m.bus_start;
    send({7'h2A, 1'h0}, 1'h1);
    send(8'h01, 1'h1);
    m.bus_stop;
    chk(ctl, 8'h55);
    m.bus_start;
    send(8'h09, 1'h1);
    chk({7'h00, hs}, 8'h01);
    m.bus_start;
    send({ADDR, 1'h0}, 1'h0);
    send(8'h01, 1'h0);
    send(8'h12, 1'h0);
    chk(ctl, 8'h12);
    m.bus_stop;
    repeat (16) @(negedge clock);
    chk({7'h00, hs}, 8'h00);
    resetn = 1'h0;
    repeat (16) @(negedge clock);
    chk(ctl, 8'h30);
    chk({7'h00, stat_en}, 8'h01);
    resetn = 1'h1;
    repeat (8) @(negedge clock);
    rd_reg(8'h01, 8'h30);
    rd_reg(8'h00, 8'h45);
    final_report;
  end
endmodule // tb_charger_status_control_regs
